// *** logic/isl_pkg.sv ***
`default_nettype none
package isl_pkg;
    // Bit slots of one byte on the bus
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] ACK_SLOT = 4'h9;
    localparam logic [3:0] BIT_ZERO = 4'h0;
    localparam logic [3:0] BIT_ONE = 4'h1;
    localparam logic [3:0] BIT_LAST_SHIFT = 4'h7;
    // Ten-bit high byte: fixed prefix, address bits 9:8 from own address bits 2:1
    localparam logic [4:0] TEN_PREFIX = 5'h1E;
    localparam int TEN_PREFIX_MSB = 7;
    localparam int TEN_PREFIX_LSB = 3;
    localparam int HI_ADDR_MSB = 2;
    localparam int HI_ADDR_LSB = 1;
    localparam int RW_BIT = 0;
    localparam int SEVEN_MSB = 7;
    localparam int SEVEN_LSB = 1;
    // Reset values
    localparam logic [7:0] OWN_ADDR_RESET = 8'h00;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic LINE_IDLE = 1'h1;
    localparam logic CLOCK_RELEASE_RESET = 1'h1;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_LOW,
        ST_RX,
        ST_TX
    } isl_state_type;
endpackage
`default_nettype wire

// *** logic/isl_slave.sv ***
`default_nettype none
// Function
// - ten-bit high byte is 11110,A9,A8,0
// - high write match sets update flag, holds SCL
// - low byte compared on all eight bits
// - low mismatch still flags and holds SCL
// - own-address write clears update flag
// - ten-bit read only after full write match
// - write address clears rw, buffers, acks
// - no ack while overflow, or while buffer full without overwrite enable, unless software acks a held byte on release
// - flag set per byte, software clears
// - stretch enable holds SCL after rx bytes
// - start sets start bit, optional flag
// - stop sets stop bit, goes idle
// - address hold stretches before ack
// - data hold stretches before ack
// - software ack value sent on release
// - ninth fall sets flag unless nack sent, except on ten-bit write address bytes
// - hold plus stretch also stretches after ack
// - read address sets rw, buffers, acks
// - after read ack hold SCL until release
// - buffer write loads shifter, msb first
// - master ack latched on ninth rise
// - master nack ends, ack stretches
// - transmit flag on ninth falling edge
// - seven-bit match ignores rw bit
// - ack phase flag at eighth fall with address or data hold
module isl_slave (
    input wire logic core_clk, // System clock
    input wire logic rst, // Synchronous reset, active high
    input wire logic linkClk, // Pin sampling clock
    input wire logic sclIn, // SCL pin level
    input wire logic sdaIn, // SDA pin level
    output logic sclOut, // SCL drive value
    output logic sclOe, // SCL pulled low when high
    output logic sdaOut, // SDA drive value
    output logic sdaOe, // SDA pulled low when high
    input wire logic tenBitMode, // Ten-bit addressing
    input wire logic startIrqEnable, // Flag on start
    input wire logic stopIrqEnable, // Flag on stop
    input wire logic stretchEnable, // Stretch after bytes
    input wire logic addressHold, // Hold before address ack
    input wire logic dataHold, // Hold before data ack
    input wire logic bufferOverwriteEnable, // Accept while buffer full
    input wire logic slaveCollisionDetectEnable, // Collision detect
    input wire logic ackValueToSend, // Ack bit for held bytes, 0 = ack
    input wire logic ownAddrWrite, // Own-address write pulse
    input wire logic [7:0] ownAddrData, // Own-address write data
    input wire logic bufWrite, // Buffer write pulse
    input wire logic [7:0] bufWriteData, // Buffer write data
    input wire logic bufRead, // Buffer read pulse
    input wire logic clockReleaseSet, // Release SCL pulse
    input wire logic irqFlagClear, // Clear interrupt flag
    input wire logic overflowClear, // Clear overflow
    input wire logic collisionClear, // Clear collision flag
    output logic [7:0] ownAddress, // Own address register
    output logic [7:0] rxTxBuffer, // Data buffer
    output logic bufferFullFlag, // Buffer holds data
    output logic receiveOverflow, // Byte arrived while full
    output logic i2cIrqFlag, // Sticky interrupt flag
    output logic clockRelease, // Low means SCL held
    output logic addrUpdateNeeded, // Own address must be rewritten
    output logic ackPhaseFlag, // Inside acknowledge time
    output logic ackReceived, // Master ack, 1 = nack
    output logic readWriteBit, // Last matched rw bit
    output logic startDetected, // Start seen last
    output logic stopDetected, // Stop seen last
    output logic collisionIrqFlag // Sticky bus collision flag
);
    logic sclL1, sclL2, sdaL1, sdaL2;
    logic sclC1, sclS, sclQ, sdaC1, sdaS, sdaQ;
    isl_pkg::isl_state_type state_r, nextState_r;
    logic [3:0] bitCnt_r;
    logic [7:0] shift_r, txShift_r, own_r, buffer_r;
    logic ackLow_r, holdPend_r, uaPend_r, priorMatch_r, rw_r;
    logic irq_r, clkRel_r, ua_r, ackPhase_r, bf_r, ov_r, ackRx_r;
    logic start_r, stop_r, coll_r, sclOe_r, sdaOe_r;
    logic sclRise, sclFall, startEv, stopEv, eighth, ninth, collEv;
    logic addrHitC, lowHitC, takeByte, refuse, holdNow, sdaNxt, needHold;

    function automatic logic hiMatch(input logic [7:0] b, input logic [7:0] own);
        return b[isl_pkg::TEN_PREFIX_MSB:isl_pkg::TEN_PREFIX_LSB] == isl_pkg::TEN_PREFIX
            && b[isl_pkg::HI_ADDR_MSB:isl_pkg::HI_ADDR_LSB]
               == own[isl_pkg::HI_ADDR_MSB:isl_pkg::HI_ADDR_LSB];
    endfunction

    function automatic logic addrHit(input logic [7:0] b, input logic [7:0] own,
                                     input logic ten);
        return ten ? hiMatch(b, own)
                   : b[isl_pkg::SEVEN_MSB:isl_pkg::SEVEN_LSB]
                     == own[isl_pkg::SEVEN_MSB:isl_pkg::SEVEN_LSB];
    endfunction

    always_ff @(posedge linkClk) begin
        sclL1 <= sclIn;
        sclL2 <= sclL1;
        sdaL1 <= sdaIn;
        sdaL2 <= sdaL1;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            sclC1 <= isl_pkg::LINE_IDLE;
            sclS <= isl_pkg::LINE_IDLE;
            sclQ <= isl_pkg::LINE_IDLE;
            sdaC1 <= isl_pkg::LINE_IDLE;
            sdaS <= isl_pkg::LINE_IDLE;
            sdaQ <= isl_pkg::LINE_IDLE;
        end else begin
            sclC1 <= sclL2;
            sclS <= sclC1;
            sclQ <= sclS;
            sdaC1 <= sdaL2;
            sdaS <= sdaC1;
            sdaQ <= sdaS;
        end
    end

    assign sclRise = sclS && !sclQ;
    assign sclFall = !sclS && sclQ;
    assign startEv = sclS && sclQ && sdaQ && !sdaS;
    assign stopEv = sclS && sclQ && !sdaQ && sdaS;
    assign eighth = sclFall && bitCnt_r == isl_pkg::BYTE_BITS && state_r != isl_pkg::ST_IDLE;
    assign ninth = sclFall && bitCnt_r == isl_pkg::ACK_SLOT && state_r != isl_pkg::ST_IDLE;

    always_comb begin
        addrHitC = state_r == isl_pkg::ST_ADDR && addrHit(shift_r, own_r, tenBitMode)
            && (!(tenBitMode && shift_r[isl_pkg::RW_BIT]) || priorMatch_r);
        lowHitC = state_r == isl_pkg::ST_LOW && shift_r == own_r;
        takeByte = addrHitC || lowHitC || state_r == isl_pkg::ST_RX;
        refuse = ov_r || (bf_r && !bufferOverwriteEnable);
        holdNow = (addressHold && (addrHitC || lowHitC))
            || (dataHold && state_r == isl_pkg::ST_RX);
    end

    // collision only while sending a one
    assign collEv = sclRise && state_r == isl_pkg::ST_TX && bitCnt_r < isl_pkg::BYTE_BITS
        && txShift_r[7] && !sdaS && slaveCollisionDetectEnable;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_r <= isl_pkg::ST_IDLE;
            nextState_r <= isl_pkg::ST_IDLE;
            bitCnt_r <= isl_pkg::BIT_ZERO;
            shift_r <= isl_pkg::BYTE_RESET;
            ackLow_r <= 1'h0;
            holdPend_r <= 1'h0;
            uaPend_r <= 1'h0;
            priorMatch_r <= 1'h0;
            rw_r <= 1'h0;
        end else if (startEv) begin
            // Restart resets the engine but keeps a prior ten-bit match
            state_r <= isl_pkg::ST_ADDR;
            bitCnt_r <= isl_pkg::BIT_ZERO;
            ackLow_r <= 1'h0;
            holdPend_r <= 1'h0;
            uaPend_r <= 1'h0;
        end else if (stopEv || collEv) begin
            state_r <= isl_pkg::ST_IDLE;
            ackLow_r <= 1'h0;
            holdPend_r <= 1'h0;
            uaPend_r <= 1'h0;
            if (stopEv) begin
                priorMatch_r <= 1'h0;
            end
        end else if (state_r != isl_pkg::ST_IDLE) begin
            if (sclRise && bitCnt_r < isl_pkg::BYTE_BITS) begin
                shift_r <= {shift_r[6:0], sdaS};
                bitCnt_r <= bitCnt_r + isl_pkg::BIT_ONE;
            end else if (sclRise && bitCnt_r == isl_pkg::BYTE_BITS) begin
                bitCnt_r <= isl_pkg::ACK_SLOT;
            end
            if (eighth) begin
                if (state_r == isl_pkg::ST_TX) begin
                    nextState_r <= isl_pkg::ST_TX;
                    ackLow_r <= 1'h0;
                end else if (takeByte) begin
                    ackLow_r <= !holdNow && !refuse;
                    holdPend_r <= holdNow;
                    if (addrHitC) begin
                        rw_r <= shift_r[isl_pkg::RW_BIT];
                        if (shift_r[isl_pkg::RW_BIT]) begin
                            nextState_r <= isl_pkg::ST_TX;
                        end else if (tenBitMode) begin
                            // high write match wants the low byte
                            nextState_r <= isl_pkg::ST_LOW;
                            uaPend_r <= 1'h1;
                            priorMatch_r <= 1'h0;
                        end else begin
                            nextState_r <= isl_pkg::ST_RX;
                        end
                    end else begin
                        nextState_r <= isl_pkg::ST_RX;
                    end
                    if (lowHitC) begin
                        uaPend_r <= 1'h1;
                        priorMatch_r <= 1'h1;
                    end
                end else if (state_r == isl_pkg::ST_LOW) begin
                    // mismatch still asks for an address update
                    uaPend_r <= 1'h1;
                    ackLow_r <= 1'h0;
                    nextState_r <= isl_pkg::ST_IDLE;
                end else begin
                    state_r <= isl_pkg::ST_IDLE;
                    if (tenBitMode && !shift_r[isl_pkg::RW_BIT]) begin
                        priorMatch_r <= 1'h0;
                    end
                end
            end else if (clockReleaseSet && holdPend_r) begin
                ackLow_r <= !ackValueToSend;
                holdPend_r <= 1'h0;
            end
            if (ninth) begin
                bitCnt_r <= isl_pkg::BIT_ZERO;
                ackLow_r <= 1'h0;
                uaPend_r <= 1'h0;
                // master nack or our nack ends the transfer
                if (state_r == isl_pkg::ST_TX ? !ackRx_r : ackLow_r) begin
                    state_r <= nextState_r;
                end else begin
                    state_r <= isl_pkg::ST_IDLE;
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            irq_r <= 1'h0;
        end else if ((startEv && startIrqEnable) || (stopEv && stopIrqEnable)
                     || (eighth && holdNow && state_r != isl_pkg::ST_TX)
                     || (ninth && (ackLow_r || uaPend_r || state_r == isl_pkg::ST_TX))) begin
            irq_r <= 1'h1;
        end else if (irqFlagClear) begin
            irq_r <= 1'h0;
        end
    end

    // Hardware clears beat a same-cycle software release
    always_ff @(posedge core_clk) begin
        if (rst) begin
            clkRel_r <= isl_pkg::CLOCK_RELEASE_RESET;
        end else if (eighth && holdNow && state_r != isl_pkg::ST_TX) begin
            clkRel_r <= 1'h0;
        end else if (ninth && state_r == isl_pkg::ST_TX && !ackRx_r) begin
            clkRel_r <= 1'h0;
        end else if (ninth && ackLow_r && state_r != isl_pkg::ST_TX
                     && nextState_r == isl_pkg::ST_TX) begin
            clkRel_r <= 1'h0;
        // receive stretch, not when the update flag holds
        end else if (ninth && ackLow_r && stretchEnable && !uaPend_r
                     && state_r != isl_pkg::ST_TX) begin
            clkRel_r <= 1'h0;
        end else if (clockReleaseSet) begin
            clkRel_r <= 1'h1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ua_r <= 1'h0;
        end else if (ninth && uaPend_r) begin
            ua_r <= 1'h1;
        end else if (ownAddrWrite) begin
            ua_r <= 1'h0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ackPhase_r <= 1'h0;
        end else if (eighth && holdNow && state_r != isl_pkg::ST_TX) begin
            ackPhase_r <= 1'h1;
        end else if (ninth || startEv || stopEv) begin
            ackPhase_r <= 1'h0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            bf_r <= 1'h0;
            ov_r <= 1'h0;
        end else begin
            if (bufWrite || (eighth && takeByte && !refuse)) begin
                bf_r <= 1'h1;
            end else if (bufRead || (eighth && state_r == isl_pkg::ST_TX)) begin
                bf_r <= 1'h0;
            end
            if (eighth && takeByte && bf_r) begin
                ov_r <= 1'h1;
            end else if (overflowClear) begin
                ov_r <= 1'h0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            buffer_r <= isl_pkg::BYTE_RESET;
        end else if (eighth && takeByte && !refuse) begin
            buffer_r <= shift_r;
        end else if (bufWrite) begin
            buffer_r <= bufWriteData;
        end
    end

    // transmit shifter moves on falling edges
    always_ff @(posedge core_clk) begin
        if (rst) begin
            txShift_r <= isl_pkg::BYTE_RESET;
        end else if (bufWrite) begin
            txShift_r <= bufWriteData;
        // Last bit stands through its high time, SDA let go only at the eighth fall
        end else if (eighth && state_r == isl_pkg::ST_TX) begin
            txShift_r <= ~isl_pkg::BYTE_RESET;
        end else if (sclFall && state_r == isl_pkg::ST_TX && bitCnt_r >= isl_pkg::BIT_ONE
                     && bitCnt_r <= isl_pkg::BIT_LAST_SHIFT) begin
            txShift_r <= {txShift_r[6:0], 1'h0};
        end
    end

    // master ack on the ninth rise
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ackRx_r <= 1'h0;
        end else if (sclRise && state_r == isl_pkg::ST_TX && bitCnt_r == isl_pkg::BYTE_BITS) begin
            ackRx_r <= sdaS;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            start_r <= 1'h0;
            stop_r <= 1'h0;
        end else if (startEv) begin
            start_r <= 1'h1;
            stop_r <= 1'h0;
        end else if (stopEv) begin
            start_r <= 1'h0;
            stop_r <= 1'h1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            coll_r <= 1'h0;
        end else if (collEv) begin
            coll_r <= 1'h1;
        end else if (collisionClear) begin
            coll_r <= 1'h0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            own_r <= isl_pkg::OWN_ADDR_RESET;
        end else if (ownAddrWrite) begin
            own_r <= ownAddrData;
        end
    end

    // SCL is only grabbed once it is already low, so no high time is cut short
    assign needHold = (!clkRel_r && state_r != isl_pkg::ST_IDLE) || ua_r;
    // ack slot drive and data drive
    assign sdaNxt = (state_r == isl_pkg::ST_TX && bitCnt_r <= isl_pkg::BYTE_BITS && !txShift_r[7])
        || (state_r != isl_pkg::ST_TX && state_r != isl_pkg::ST_IDLE && ackLow_r
            && !holdPend_r && bitCnt_r >= isl_pkg::BYTE_BITS);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            sclOe_r <= 1'h0;
            sdaOe_r <= 1'h0;
        end else begin
            // Keep SCL one more cycle while SDA settles, so both lines never move together
            sclOe_r <= (needHold || (sclOe_r && sdaNxt != sdaOe_r)) && (!sclS || sclOe_r);
            sdaOe_r <= sdaNxt;
        end
    end

    assign sclOut = 1'h0;
    assign sdaOut = 1'h0;
    assign sclOe = sclOe_r;
    assign sdaOe = sdaOe_r;
    assign ownAddress = own_r;
    assign rxTxBuffer = buffer_r;
    assign bufferFullFlag = bf_r;
    assign receiveOverflow = ov_r;
    assign i2cIrqFlag = irq_r;
    assign clockRelease = clkRel_r;
    assign addrUpdateNeeded = ua_r;
    assign ackPhaseFlag = ackPhase_r;
    assign ackReceived = ackRx_r;
    assign readWriteBit = rw_r;
    assign startDetected = start_r;
    assign stopDetected = stop_r;
    assign collisionIrqFlag = coll_r;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_quietBus;
        !sclFall && !startEv && !stopEv && !collEv;
    endsequence

    a_irq_sticky: assert property (irq_r && !irqFlagClear |=> irq_r)
        else $error("interrupt flag dropped without clear");
    a_start_seen: assert property (startEv |=> start_r && state_r == isl_pkg::ST_ADDR)
        else $error("start not recorded");
    a_stop_idle: assert property (stopEv |=> stop_r && state_r == isl_pkg::ST_IDLE)
        else $error("stop did not idle the engine");
    a_ack_latch: assert property (sclRise && state_r == isl_pkg::ST_TX
        && bitCnt_r == isl_pkg::BYTE_BITS && !startEv && !stopEv |=> ackRx_r == $past(sdaS))
        else $error("master ack not latched");
    a_ua_clear: assert property (ownAddrWrite && !(ninth && uaPend_r) |=> !ua_r)
        else $error("update flag survived address write");
    a_ua_hold: assert property (ua_r && !sclS ##1 ua_r |-> sclOe_r)
        else $error("SCL not held for address update");
    a_read_stretch: assert property (ninth && ackLow_r && state_r == isl_pkg::ST_ADDR
        && nextState_r == isl_pkg::ST_TX && !startEv && !stopEv
        |=> !clkRel_r && state_r == isl_pkg::ST_TX && irq_r)
        else $error("read request not stretched");
    a_addr_hold: assert property (eighth && addressHold && addrHitC
        && !startEv && !stopEv |=> irq_r && !clkRel_r && ackPhase_r)
        else $error("address hold missed");
    a_tx_stable: assert property ((s_quietBus and state_r == isl_pkg::ST_TX && !bufWrite)
        ##1 (s_quietBus and !bufWrite) |=> $stable(sdaOe_r))
        else $error("SDA changed away from a falling edge");
    a_nack_idle: assert property (ninth && state_r == isl_pkg::ST_TX && ackRx_r
        && !startEv && !stopEv |=> state_r == isl_pkg::ST_IDLE && irq_r)
        else $error("master nack not handled");
endmodule
`default_nettype wire

// *** verification/isl_master_model.sv ***
`default_nettype none
module isl_master_model (
    input wire logic scl, // Resolved clock line
    input wire logic sda, // Resolved data line
    output logic sclLow, // Pull clock low
    output logic sdaLow // Pull data low
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int QTR = 1000;
    initial begin
        sclLow = 1'h0;
        sdaLow = 1'h0;
    end
    task automatic rise();
        sclLow = 1'h0;
        for (int n = 0; n < 4000 && scl !== 1'h1; n++) #50;
        #QTR;
    endtask
    // Also serves as restart from a low clock
    task automatic start_cond();
        sdaLow = 1'h0;
        #QTR;
        rise();
        sdaLow = 1'h1;
        #QTR;
        sclLow = 1'h1;
        #QTR;
    endtask
    task automatic stop_cond();
        sdaLow = 1'h1;
        #QTR;
        rise();
        sdaLow = 1'h0;
        #QTR;
    endtask
    task automatic xfer(input logic [7:0] tx, input logic ackIn, output logic [7:0] rx,
                        output logic ackOut);
        for (int i = 8; i >= 0; i--) begin
            sdaLow = (i > 0) ? !tx[i-1] : !ackIn;
            #QTR;
            rise();
            if (i > 0) rx[i-1] = sda;
            else ackOut = sda;
            sclLow = 1'h1;
            #QTR;
        end
    endtask
endmodule
`default_nettype wire

// *** verification/i2c_slave_addr_rx_tx_tb.sv ***
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_count++; \
    $display("Error at %0t: got %h expected %h", $time, g, e); end end
module i2c_slave_addr_rx_tx_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk, rst, linkClk, tenBitMode, startIrqEnable, stopIrqEnable, stretchEnable;
    logic addressHold, dataHold, bufferOverwriteEnable, slaveCollisionDetectEnable;
    logic ackValueToSend, ownAddrWrite, bufWrite, bufRead, clockReleaseSet, irqFlagClear;
    logic overflowClear, collisionClear, sclOut, sclOe, sdaOut, sdaOe, bufferFullFlag;
    logic receiveOverflow, i2cIrqFlag, clockRelease, addrUpdateNeeded, ackPhaseFlag;
    logic ackReceived, readWriteBit, startDetected, stopDetected, collisionIrqFlag;
    logic mSclLow, mSdaLow, ackBit;
    logic [7:0] ownAddrData, bufWriteData, ownAddress, rxTxBuffer, rxByte, noData;
    int err_count = 0;
    int check_count = 0;
    wire sclLine;
    wire sdaLine;
    assign sclLine = !(mSclLow | sclOe);
    assign sdaLine = !(mSdaLow | sdaOe);
    isl_slave u_isl_slave (.core_clk, .rst, .linkClk, .sclIn(sclLine), .sdaIn(sdaLine),
        .sclOut, .sclOe, .sdaOut, .sdaOe, .tenBitMode, .startIrqEnable, .stopIrqEnable,
        .stretchEnable, .addressHold, .dataHold, .bufferOverwriteEnable,
        .slaveCollisionDetectEnable, .ackValueToSend, .ownAddrWrite, .ownAddrData, .bufWrite,
        .bufWriteData, .bufRead, .clockReleaseSet, .irqFlagClear, .overflowClear,
        .collisionClear, .ownAddress, .rxTxBuffer, .bufferFullFlag, .receiveOverflow,
        .i2cIrqFlag, .clockRelease, .addrUpdateNeeded, .ackPhaseFlag, .ackReceived,
        .readWriteBit, .startDetected, .stopDetected, .collisionIrqFlag);
    isl_master_model u_isl_master_model (.scl(sclLine), .sda(sdaLine), .sclLow(mSclLow),
        .sdaLow(mSdaLow));
    initial begin
        core_clk = 1'h0;
        forever #25 core_clk = ~core_clk;
    end
    // Unrelated phase to the core clock
    initial begin
        linkClk = 1'h0;
        #7;
        forever #24 linkClk = ~linkClk;
    end
    task automatic pulse(ref logic s, ref logic [7:0] d, input logic [7:0] v);
        @(posedge core_clk);
        #2 d = v;
        s = 1'h1;
        @(posedge core_clk);
        #2 s = 1'h0;
    endtask
    task automatic t_write();
        stretchEnable = 1'h1;
        stopIrqEnable = 1'h1;
        pulse(ownAddrWrite, ownAddrData, 8'hB4);
        u_isl_master_model.start_cond();
        `CHK({startDetected, i2cIrqFlag}, 2'h3)
        pulse(irqFlagClear, noData, 8'h00);
        u_isl_master_model.xfer(8'hB4, 1'h1, rxByte, ackBit);
        `CHK({ackBit, readWriteBit}, 2'h0)
        `CHK(rxTxBuffer, 8'hB4)
        `CHK({bufferFullFlag, ownAddress}, 9'h1B4)
        `CHK({i2cIrqFlag, clockRelease, sclOe}, 3'h5)
        pulse(irqFlagClear, noData, 8'h00);
        pulse(bufRead, noData, 8'h00);
        pulse(clockReleaseSet, noData, 8'h00);
        u_isl_master_model.xfer(8'h3C, 1'h1, rxByte, ackBit);
        `CHK({ackBit, rxTxBuffer}, 9'h03C)
        `CHK({i2cIrqFlag, clockRelease}, 2'h2)
        pulse(irqFlagClear, noData, 8'h00);
        pulse(clockReleaseSet, noData, 8'h00);
        u_isl_master_model.xfer(8'h11, 1'h1, rxByte, ackBit);
        `CHK({ackBit, receiveOverflow, rxTxBuffer}, 10'h33C)
        `CHK(i2cIrqFlag, 1'h0)
        pulse(clockReleaseSet, noData, 8'h00);
        u_isl_master_model.stop_cond();
        `CHK({stopDetected, i2cIrqFlag}, 2'h3)
        pulse(overflowClear, noData, 8'h00);
        pulse(bufRead, noData, 8'h00);
    endtask
    task automatic t_miss();
        u_isl_master_model.start_cond();
        pulse(irqFlagClear, noData, 8'h00);
        u_isl_master_model.xfer(8'hB6, 1'h1, rxByte, ackBit);
        `CHK({ackBit, i2cIrqFlag}, 2'h2)
        u_isl_master_model.stop_cond();
    endtask
    task automatic t_read();
        addressHold = 1'h1;
        slaveCollisionDetectEnable = 1'h1;
        u_isl_master_model.start_cond();
        pulse(irqFlagClear, noData, 8'h00);
        fork
            u_isl_master_model.xfer(8'hB5, 1'h1, rxByte, ackBit);
            begin
                for (int n = 0; n < 2000 && i2cIrqFlag !== 1'h1; n++) @(posedge core_clk);
                `CHK({ackPhaseFlag, clockRelease}, 2'h2)
                `CHK(rxTxBuffer, 8'hB5)
                pulse(irqFlagClear, noData, 8'h00);
                ackValueToSend = 1'h0;
                pulse(clockReleaseSet, noData, 8'h00);
            end
        join
        `CHK({ackBit, readWriteBit, i2cIrqFlag, clockRelease}, 4'h6)
        `CHK(ackPhaseFlag, 1'h0)
        addressHold = 1'h0;
        pulse(irqFlagClear, noData, 8'h00);
        pulse(bufWrite, bufWriteData, 8'hA5);
        pulse(clockReleaseSet, noData, 8'h00);
        u_isl_master_model.xfer(8'hFF, 1'h0, rxByte, ackBit);
        `CHK(rxByte, 8'hA5)
        `CHK({ackReceived, i2cIrqFlag, clockRelease}, 3'h2)
        pulse(irqFlagClear, noData, 8'h00);
        pulse(bufWrite, bufWriteData, 8'h96);
        pulse(clockReleaseSet, noData, 8'h00);
        u_isl_master_model.xfer(8'hFF, 1'h1, rxByte, ackBit);
        `CHK(rxByte, 8'h96)
        `CHK({ackReceived, i2cIrqFlag, clockRelease}, 3'h7)
        `CHK({collisionIrqFlag, sclOut, sdaOut}, 3'h0)
        u_isl_master_model.stop_cond();
    endtask
    task automatic t_ten();
        tenBitMode = 1'h1;
        stretchEnable = 1'h0;
        pulse(ownAddrWrite, ownAddrData, 8'h04);
        u_isl_master_model.start_cond();
        pulse(irqFlagClear, noData, 8'h00);
        u_isl_master_model.xfer(8'hF4, 1'h1, rxByte, ackBit);
        `CHK(ackBit, 1'h0)
        `CHK({addrUpdateNeeded, i2cIrqFlag, sclOe}, 3'h7)
        pulse(irqFlagClear, noData, 8'h00);
        pulse(bufRead, noData, 8'h00);
        pulse(ownAddrWrite, ownAddrData, 8'h37);
        `CHK(addrUpdateNeeded, 1'h0)
        u_isl_master_model.xfer(8'h36, 1'h1, rxByte, ackBit);
        `CHK(ackBit, 1'h1)
        `CHK({addrUpdateNeeded, i2cIrqFlag, sclOe}, 3'h7)
        pulse(ownAddrWrite, ownAddrData, 8'h04);
        u_isl_master_model.stop_cond();
        tenBitMode = 1'h0;
    endtask
    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        {tenBitMode, stopIrqEnable, stretchEnable, addressHold, dataHold} = 5'h00;
        {bufferOverwriteEnable, slaveCollisionDetectEnable, ownAddrWrite, bufWrite} = 4'h0;
        {bufRead, clockReleaseSet, irqFlagClear, overflowClear, collisionClear} = 5'h00;
        {ownAddrData, bufWriteData, noData} = 24'h000000;
        startIrqEnable = 1'h1;
        ackValueToSend = 1'h1;
        rst = 1'h1;
        repeat (6) @(posedge core_clk);
        #2 rst = 1'h0;
        repeat (4) @(posedge core_clk);
        #2;
        t_write();
        t_miss();
        t_read();
        t_ten();
        report_and_stop();
    end
    // Whole run needs well under a millisecond
    initial begin
        #2000000;
        err_count++;
        report_and_stop();
    end
endmodule
`default_nettype wire
